/* design/asf_pkg.sv */
`default_nettype none
package asf_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] PSW_IDX  = 8'hD0;
  localparam logic [7:0] POWER_CONTROL_IDX = 8'h87;
  localparam logic [ADDR_W-1:0] PSW_ADDR  = {2'h0, PSW_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] POWER_CONTROL_ADDR = {2'h0, POWER_CONTROL_IDX, 2'h0};

  // Program status word bit positions
  localparam int unsigned PSW_CY  = 7;
  localparam int unsigned PSW_AC  = 6;
  localparam int unsigned PSW_F0  = 5;
  localparam int unsigned PSW_RS1 = 4;
  localparam int unsigned PSW_RS0 = 3;
  localparam int unsigned PSW_OV  = 2;
  localparam int unsigned PSW_F1  = 1;
  localparam int unsigned PSW_P   = 0;

  // Power control bit positions
  localparam int unsigned POWER_CONTROL_SMOD = 7;
  localparam int unsigned POWER_CONTROL_POF  = 4;
  localparam int unsigned POWER_CONTROL_GF1  = 3;
  localparam int unsigned POWER_CONTROL_GF0  = 2;
  localparam int unsigned POWER_CONTROL_PD   = 1;
  localparam int unsigned POWER_CONTROL_IDL  = 0;

  localparam logic [7:0] PSW_RST  = 8'h00;
  localparam logic [7:0] POWER_CONTROL_RST = 8'h00;

  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [8:0] DA_LOW_ADJ    = 9'h006;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_ADD,
    OP_ADD_WITH_CARRY,
    OP_SUBTRACT_WITH_BORROW,
    OP_UNSIGNED_MULTIPLY,
    OP_DIVIDE,
    OP_DECIMAL_ADJUST,
    OP_ROTATE_RIGHT_THROUGH_CARRY,
    OP_ROTATE_LEFT_THROUGH_CARRY,
    OP_COMPARE_JUMP_NOT_EQUAL,
    OP_SET_CARRY,
    OP_CLEAR_CARRY,
    OP_COMPLEMENT_CARRY,
    OP_AND_CARRY_BIT,
    OP_AND_CARRY_NOT_BIT,
    OP_OR_CARRY_BIT,
    OP_OR_CARRY_NOT_BIT,
    OP_MOVE_BIT_TO_CARRY
  } asf_op_t;

endpackage
`default_nettype wire

/* design/asf_flag_if.sv */
`default_nettype none
interface asf_flag_if;
  import asf_pkg::*;

  asf_op_t    op;
  logic [7:0] opa;
  logic [7:0] opb;
  logic       bit_val;
  logic       cy_in;
  logic       ac_in;
  logic       upd_cy;
  logic       upd_ac;
  logic       upd_ov;
  logic       cy_new;
  logic       ac_new;
  logic       ov_new;

  modport core (output op, opa, opb, bit_val, cy_in, ac_in,
                input  upd_cy, upd_ac, upd_ov, cy_new, ac_new, ov_new);
  modport calc (input  op, opa, opb, bit_val, cy_in, ac_in,
                output upd_cy, upd_ac, upd_ov, cy_new, ac_new, ov_new);
endinterface
`default_nettype wire

/* design/asf_flag_calc.sv */
`default_nettype none
module asf_flag_calc
  import asf_pkg::*;
(
  asf_flag_if.calc fi
);

  logic [8:0]  sum9;
  logic [4:0]  sum_lo;
  logic [7:0]  sum_b6;
  logic [8:0]  dif9;
  logic [4:0]  dif_lo;
  logic [7:0]  dif_b6;
  logic [15:0] prod;
  logic [8:0]  da_lo;
  logic        cin;

  always_comb begin
    cin    = (fi.op == OP_ADD_WITH_CARRY) ? fi.cy_in : 1'b0;
    sum9   = {1'b0, fi.opa} + {1'b0, fi.opb} + {8'h00, cin};
    sum_lo = {1'b0, fi.opa[3:0]} + {1'b0, fi.opb[3:0]} + {4'h0, cin};
    sum_b6 = {1'b0, fi.opa[6:0]} + {1'b0, fi.opb[6:0]} + {7'h00, cin};
    dif9   = {1'b0, fi.opa} - {1'b0, fi.opb} - {8'h00, fi.cy_in};
    dif_lo = {1'b0, fi.opa[3:0]} - {1'b0, fi.opb[3:0]}
             - {4'h0, fi.cy_in};
    dif_b6 = {1'b0, fi.opa[6:0]} - {1'b0, fi.opb[6:0]}
             - {7'h00, fi.cy_in};
    prod   = fi.opa * fi.opb;
    // Low digit is corrected first; high digit correction overflows
    // exactly when that digit exceeds nine after it
    da_lo  = {1'b0, fi.opa} +
             (((fi.opa[3:0] > BCD_MAX_DIGIT) || fi.ac_in) ?
              DA_LOW_ADJ : 9'h000);
  end

  always_comb begin
    fi.upd_cy = 1'b0;
    fi.upd_ac = 1'b0;
    fi.upd_ov = 1'b0;
    fi.cy_new = fi.cy_in;
    fi.ac_new = fi.ac_in;
    fi.ov_new = 1'b0;
    case (fi.op)
      OP_ADD, OP_ADD_WITH_CARRY: begin
        fi.upd_cy = 1'b1;                                      // [RULE7]
        fi.upd_ac = 1'b1;
        fi.upd_ov = 1'b1;
        fi.cy_new = sum9[8];                                   // [RULE10]
        fi.ac_new = sum_lo[4];                                 // [RULE11]
        fi.ov_new = sum_b6[7] ^ sum9[8];                       // [RULE1]
      end
      OP_SUBTRACT_WITH_BORROW: begin
        fi.upd_cy = 1'b1;                                      // [RULE7]
        fi.upd_ac = 1'b1;
        fi.upd_ov = 1'b1;
        fi.cy_new = dif9[8];                                   // [RULE10]
        fi.ac_new = dif_lo[4];                                 // [RULE11]
        fi.ov_new = dif_b6[7] ^ dif9[8];                       // [RULE2]
      end
      OP_UNSIGNED_MULTIPLY: begin
        fi.upd_cy = 1'b1;
        fi.upd_ov = 1'b1;
        fi.cy_new = 1'b0;                                      // [RULE7]
        fi.ov_new = |prod[15:8];                               // [RULE3]
      end
      OP_DIVIDE: begin
        fi.upd_cy = 1'b1;
        fi.upd_ov = 1'b1;
        fi.cy_new = 1'b0;                                      // [RULE7]
        fi.ov_new = (fi.opb == 8'h00);                         // [RULE4]
      end
      OP_DECIMAL_ADJUST: begin
        fi.upd_cy = 1'b1;                                      // [RULE8]
        fi.cy_new = fi.cy_in | da_lo[8] |
                    (da_lo[7:4] > BCD_MAX_DIGIT);
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = fi.opa[0];                                 // [RULE8]
      end
      OP_ROTATE_LEFT_THROUGH_CARRY: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = fi.opa[7];                                 // [RULE8]
      end
      OP_COMPARE_JUMP_NOT_EQUAL: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = (fi.opa < fi.opb);                         // [RULE10]
      end
      OP_SET_CARRY: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = 1'b1;                                      // [RULE7]
      end
      OP_CLEAR_CARRY: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = 1'b0;                                      // [RULE7]
      end
      OP_COMPLEMENT_CARRY: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = ~fi.cy_in;                                 // [RULE8]
      end
      OP_AND_CARRY_BIT: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = fi.cy_in & fi.bit_val;
      end
      OP_AND_CARRY_NOT_BIT: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = fi.cy_in & ~fi.bit_val;
      end
      OP_OR_CARRY_BIT: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = fi.cy_in | fi.bit_val;
      end
      OP_OR_CARRY_NOT_BIT: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = fi.cy_in | ~fi.bit_val;
      end
      OP_MOVE_BIT_TO_CARRY: begin
        fi.upd_cy = 1'b1;
        fi.cy_new = fi.bit_val;
      end
      default: begin
        fi.upd_cy = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

/* design/asf_status_flags.sv */
`default_nettype none
// Contract
// RULE1: Add and add-with-carry set overflow when exactly one of carries 6, 7.
// RULE2: Subtract-with-borrow sets overflow on borrow into exactly one of 6, 7.
// RULE3: Multiply sets overflow when the product exceeds 255, else clears.
// RULE4: Divide clears overflow, but sets it when the divisor was zero.
// RULE5: Parity is one for an odd count of accumulator ones.
// RULE6: User flag one is software read/write only; instructions never touch it.
// RULE7: Each instruction class updates or forces exactly its listed flags.
// RULE8: Unforced modified flags come from the result; unlisted flags hold.
// RULE9: Power control bits 3 and 2 are free software flags only.
// RULE10: Carry marks carry or borrow at the top bit; compare sets on less.
// RULE11: Auxiliary carry marks carry or borrow at the low nibble boundary.
// RULE12: Software writes load writable bits; parity keeps following accumulator.
module asf_status_flags
  import asf_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  output var  logic              pready,
  output var  logic [DATA_W-1:0] prdata,
  output var  logic              pslverr,
  input  wire logic              op_valid,
  input  wire asf_op_t           op_code,
  input  wire logic [7:0]        op_a,
  input  wire logic [7:0]        op_b,
  input  wire logic              op_bit,
  input  wire logic [7:0]        acc,
  output var  logic              carry_flag,
  output var  logic              aux_carry_flag,
  output var  logic              overflow_flag,
  output var  logic              parity_flag,
  output var  logic              user_flag_zero,
  output var  logic              user_flag_one,
  output var  logic [1:0]        bank_select,
  output var  logic              general_flag_one,
  output var  logic              general_flag_zero
);

  logic       pready_q;
  logic       pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic       cy_q;
  logic       ac_q;
  logic       ov_q;
  logic       f0_q;
  logic       f1_q;
  logic [1:0] rs_q;
  logic       par_q;
  logic [7:0] power_control_q;

  logic       psw_hit;
  logic       power_control_hit;
  logic       rd_sample;
  logic       commit;
  logic       psw_wr;
  logic       power_control_wr;
  logic [7:0] psw_view;
  logic [7:0] power_control_view;
  logic [7:0] wbyte;

  asf_flag_if fif ();

  asf_flag_calc u_calc (
    .fi (fif.calc)
  );

  // Idle cycles present no instruction so nothing can leak into the flags
  always_comb begin
    fif.op      = op_valid ? op_code : OP_NONE;
    fif.opa     = op_a;
    fif.opb     = op_b;
    fif.bit_val = op_bit;
    fif.cy_in   = cy_q;
    fif.ac_in   = ac_q;
  end

  always_comb begin
    if (paddr == PSW_ADDR) begin
      psw_hit  = 1'b1;
      power_control_hit = 1'b0;
    end else if (paddr == POWER_CONTROL_ADDR) begin
      psw_hit  = 1'b0;
      power_control_hit = 1'b1;
    end else begin
      psw_hit  = 1'b0;
      power_control_hit = 1'b0;
    end
  end

  // One wait state: data is sampled in the first access cycle and the
  // write lands on the edge that also completes the transfer
  assign rd_sample = psel & penable & ~pready_q;
  assign commit    = psel & penable & pready_q;
  assign psw_wr    = commit & pwrite & psw_hit;
  assign power_control_wr   = commit & pwrite & power_control_hit;
  assign wbyte     = pwdata[7:0];

  always_comb begin
    psw_view          = PSW_RST;
    psw_view[PSW_CY]  = cy_q;
    psw_view[PSW_AC]  = ac_q;
    psw_view[PSW_F0]  = f0_q;
    psw_view[PSW_RS1] = rs_q[1];
    psw_view[PSW_RS0] = rs_q[0];
    psw_view[PSW_OV]  = ov_q;
    psw_view[PSW_F1]  = f1_q;
    psw_view[PSW_P]   = par_q;                                 // [RULE12]
  end

  always_comb begin
    power_control_view            = POWER_CONTROL_RST;
    power_control_view[POWER_CONTROL_SMOD] = power_control_q[POWER_CONTROL_SMOD];
    power_control_view[POWER_CONTROL_POF]  = power_control_q[POWER_CONTROL_POF];
    power_control_view[POWER_CONTROL_GF1]  = power_control_q[POWER_CONTROL_GF1];
    power_control_view[POWER_CONTROL_GF0]  = power_control_q[POWER_CONTROL_GF0];
    power_control_view[POWER_CONTROL_PD]   = power_control_q[POWER_CONTROL_PD];
    power_control_view[POWER_CONTROL_IDL]  = power_control_q[POWER_CONTROL_IDL];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= rd_sample;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= rd_sample & ~psw_hit & ~power_control_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_sample && !pwrite) begin
      if (psw_hit) begin
        prdata_q <= {24'h00_0000, psw_view};
      end else if (power_control_hit) begin
        prdata_q <= {24'h00_0000, power_control_view};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end else if (commit) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // Instruction results win over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cy_q <= PSW_RST[PSW_CY];
    end else if (fif.upd_cy) begin
      cy_q <= fif.cy_new;                                      // [RULE7] [RULE8]
    end else if (psw_wr) begin
      cy_q <= wbyte[PSW_CY];                                   // [RULE12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_q <= PSW_RST[PSW_AC];
    end else if (fif.upd_ac) begin
      ac_q <= fif.ac_new;                                      // [RULE11]
    end else if (psw_wr) begin
      ac_q <= wbyte[PSW_AC];                                   // [RULE12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_q <= PSW_RST[PSW_OV];
    end else if (fif.upd_ov) begin
      ov_q <= fif.ov_new;                                      // [RULE1] [RULE3]
    end else if (psw_wr) begin
      ov_q <= wbyte[PSW_OV];                                   // [RULE12]
    end
  end

  // Software-only status bits; no instruction path reaches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f0_q <= PSW_RST[PSW_F0];
      f1_q <= PSW_RST[PSW_F1];
      rs_q <= PSW_RST[PSW_RS1:PSW_RS0];
    end else if (psw_wr) begin
      f0_q <= wbyte[PSW_F0];
      f1_q <= wbyte[PSW_F1];                                   // [RULE6]
      rs_q <= wbyte[PSW_RS1:PSW_RS0];
    end
  end

  // Parity trails the accumulator by one clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_q <= PSW_RST[PSW_P];
    end else begin
      par_q <= ^acc;                                           // [RULE5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_q <= POWER_CONTROL_RST;
    end else if (power_control_wr) begin
      power_control_q[POWER_CONTROL_SMOD] <= wbyte[POWER_CONTROL_SMOD];
      power_control_q[POWER_CONTROL_POF]  <= wbyte[POWER_CONTROL_POF];
      power_control_q[POWER_CONTROL_GF1]  <= wbyte[POWER_CONTROL_GF1];                    // [RULE9]
      power_control_q[POWER_CONTROL_GF0]  <= wbyte[POWER_CONTROL_GF0];                    // [RULE9]
      power_control_q[POWER_CONTROL_PD]   <= wbyte[POWER_CONTROL_PD];
      power_control_q[POWER_CONTROL_IDL]  <= wbyte[POWER_CONTROL_IDL];
    end
  end

  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign prdata            = prdata_q;
  assign carry_flag        = cy_q;
  assign aux_carry_flag    = ac_q;
  assign overflow_flag     = ov_q;
  assign parity_flag       = par_q;
  assign user_flag_zero    = f0_q;
  assign user_flag_one     = f1_q;
  assign bank_select       = rs_q;
  assign general_flag_one  = power_control_q[POWER_CONTROL_GF1];
  assign general_flag_zero = power_control_q[POWER_CONTROL_GF0];

endmodule
`default_nettype wire

/* testbench/asf_flags_checker.sv */
`default_nettype none
module asf_flags_checker
  import asf_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       op_valid,
  input wire asf_op_t    op_code,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic [7:0] acc,
  input wire logic       carry_flag,
  input wire logic       aux_carry_flag,
  input wire logic       overflow_flag,
  input wire logic       parity_flag,
  input wire logic       user_flag_one,
  input wire logic       general_flag_one,
  input wire logic       general_flag_zero
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] add_w;
  logic [8:0] sub_w;
  logic       cin;
  logic       ac_a;
  logic       ac_s;
  logic       ov_a;
  logic       ov_s;
  logic       co_a;
  logic       bo_s;
  logic       lt_w;
  always_comb begin
    cin   = carry_flag && op_code != OP_ADD;
    add_w = {1'b0, op_a} + {1'b0, op_b} + 9'(cin);
    sub_w = {1'b0, op_a} - {1'b0, op_b} - 9'(carry_flag);
    ac_a  = 5'(op_a[3:0]) + 5'(op_b[3:0]) + 5'(cin) > 5'h0F;
    ac_s  = 5'(op_a[3:0]) < 5'(op_b[3:0]) + 5'(carry_flag);
    ov_a  = op_a[7] == op_b[7] && add_w[7] != op_a[7];
    ov_s  = op_a[7] != op_b[7] && sub_w[7] != op_a[7];
    co_a  = add_w[8];
    bo_s  = sub_w[8];
    lt_w  = op_a < op_b;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_add;
    op_valid && (op_code == OP_ADD || op_code == OP_ADD_WITH_CARRY);
  endsequence
  sequence s_sub;
    op_valid && op_code == OP_SUBTRACT_WITH_BORROW;
  endsequence
  AST_ADD_FLAGS:
    assert property (s_add |=> overflow_flag == $past(ov_a) &&
      carry_flag == $past(co_a) && aux_carry_flag == $past(ac_a))
    else $error("add flags wrong");
  AST_SUB_FLAGS:
    assert property (s_sub |=> overflow_flag == $past(ov_s) &&
      carry_flag == $past(bo_s) && aux_carry_flag == $past(ac_s))
    else $error("subtract flags wrong");
  AST_MULTIPLY_FLAGS:
    assert property (op_valid && op_code == OP_UNSIGNED_MULTIPLY |=>
      !carry_flag && overflow_flag == ($past(op_a) * $past(op_b) > 255))
    else $error("multiply flags wrong");
  AST_DIV_FLAGS:
    assert property (op_valid && op_code == OP_DIVIDE |=>
      !carry_flag && overflow_flag == ($past(op_b) == 8'h00))
    else $error("divide flags wrong");
  AST_PARITY:
    assert property ($past(presetn) |-> parity_flag == ^$past(acc))
    else $error("parity does not follow accumulator");
  AST_SW_FLAGS_HOLD:
    assert property (!psel |=> $stable(user_flag_one) &&
      $stable(general_flag_one) && $stable(general_flag_zero))
    else $error("software flag moved without a write");
  AST_CARRY_FORCED:
    assert property (op_valid && op_code inside {OP_SET_CARRY,
      OP_CLEAR_CARRY} |=> carry_flag == ($past(op_code) == OP_SET_CARRY))
    else $error("forced carry wrong");
  AST_COMPARE_CARRY:
    assert property (op_valid && op_code == OP_COMPARE_JUMP_NOT_EQUAL
      |=> carry_flag == $past(lt_w))
    else $error("compare carry wrong");
  AST_UNLISTED_HOLD:
    assert property (op_valid && !psel && !(op_code inside {OP_ADD,
      OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_UNSIGNED_MULTIPLY,
      OP_DIVIDE}) |=> $stable(overflow_flag) && $stable(aux_carry_flag))
    else $error("unlisted flag changed");
endmodule
bind asf_status_flags asf_flags_checker i_asf_flags_checker (
  .pclk, .presetn, .psel, .op_valid, .op_code, .op_a, .op_b, .acc,
  .carry_flag, .aux_carry_flag, .overflow_flag, .parity_flag,
  .user_flag_one, .general_flag_one, .general_flag_zero
);
`default_nettype wire

/* testbench/asf_core_model.sv */
`default_nettype none
module asf_core_model
  import asf_pkg::*;
(
  input  wire logic       pclk,
  output var  logic       op_valid,
  output var  asf_op_t    op_code,
  output var  logic [7:0] op_a,
  output var  logic [7:0] op_b,
  output var  logic       op_bit,
  output var  logic [7:0] acc
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    op_valid = 1'b0;
    op_code  = OP_NONE;
    op_a     = 8'h00;
    op_b     = 8'h00;
    op_bit   = 1'b0;
    acc      = 8'h00;
  end
  task automatic exec(input asf_op_t c, input logic [7:0] a,
                      input logic [7:0] b, input logic t);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_code  <= c;
    op_a     <= a;
    op_b     <= b;
    op_bit   <= t;
  endtask
  // Operand buses keep moving between instructions, as a real datapath's do
  task automatic idle();
    @(posedge pclk);
    op_valid <= 1'b0;
    op_a     <= ~op_a;
    op_b     <= ~op_b;
    op_bit   <= ~op_bit;
  endtask
  task automatic set_acc(input logic [7:0] v);
    @(posedge pclk);
    acc <= v;
  endtask
endmodule
`default_nettype wire

/* testbench/alu_status_flag_logic_tb.sv */
`default_nettype none
module alu_status_flag_logic_tb
  import asf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    asf_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       bt;
    logic [2:0] f;
  } asf_vec_t;
  logic              pclk;
  logic              presetn;
  logic [ADDR_W-1:0] paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [DATA_W-1:0] pwdata;
  logic              pready;
  logic [DATA_W-1:0] prdata;
  logic              pslverr;
  logic              op_valid;
  asf_op_t           op_code;
  logic [7:0]        op_a;
  logic [7:0]        op_b;
  logic              op_bit;
  logic [7:0]        acc;
  logic              carry_flag;
  logic              aux_carry_flag;
  logic              overflow_flag;
  logic              parity_flag;
  logic              user_flag_zero;
  logic              user_flag_one;
  logic [1:0]        bank_select;
  logic              general_flag_one;
  logic              general_flag_zero;
  logic [DATA_W-1:0] rd;
  logic              er;
  int                fails = 0;
  int                comparisons = 0;
  // Expected carry, aux carry, overflow after each op, run back to back
  asf_vec_t vec [23] = '{
    '{OP_ADD, 8'h7F, 8'h01, 1'b0, 3'h3},
    '{OP_ADD, 8'hFF, 8'h01, 1'b0, 3'h6},
    '{OP_ADD_WITH_CARRY, 8'h80, 8'h80, 1'b0, 3'h5},
    '{OP_SUBTRACT_WITH_BORROW, 8'h80, 8'h01, 1'b0, 3'h3},
    '{OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h01, 1'b0, 3'h6},
    '{OP_UNSIGNED_MULTIPLY, 8'h10, 8'h10, 1'b0, 3'h3},
    '{OP_UNSIGNED_MULTIPLY, 8'h0F, 8'h11, 1'b0, 3'h2},
    '{OP_DIVIDE, 8'h05, 8'h00, 1'b0, 3'h3},
    '{OP_DIVIDE, 8'h05, 8'h01, 1'b0, 3'h2},
    '{OP_SET_CARRY, 8'h00, 8'h00, 1'b0, 3'h6},
    '{OP_CLEAR_CARRY, 8'h00, 8'h00, 1'b0, 3'h2},
    '{OP_COMPARE_JUMP_NOT_EQUAL, 8'h01, 8'h02, 1'b0, 3'h6},
    '{OP_COMPARE_JUMP_NOT_EQUAL, 8'h02, 8'h01, 1'b0, 3'h2},
    '{OP_DECIMAL_ADJUST, 8'h9A, 8'h00, 1'b0, 3'h6},
    '{OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h02, 8'h00, 1'b0, 3'h2},
    '{OP_ROTATE_LEFT_THROUGH_CARRY, 8'h80, 8'h00, 1'b0, 3'h6},
    '{OP_COMPLEMENT_CARRY, 8'h00, 8'h00, 1'b0, 3'h2},
    '{OP_MOVE_BIT_TO_CARRY, 8'h00, 8'h00, 1'b1, 3'h6},
    '{OP_AND_CARRY_BIT, 8'h00, 8'h00, 1'b0, 3'h2},
    '{OP_OR_CARRY_NOT_BIT, 8'h00, 8'h00, 1'b0, 3'h6},
    '{OP_AND_CARRY_NOT_BIT, 8'h00, 8'h00, 1'b1, 3'h2},
    '{OP_OR_CARRY_BIT, 8'h00, 8'h00, 1'b1, 3'h6},
    '{OP_NONE, 8'hFF, 8'hFF, 1'b1, 3'h6}};
  asf_status_flags i_asf_status_flags (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .prdata, .pslverr, .op_valid, .op_code, .op_a, .op_b, .op_bit, .acc,
    .carry_flag, .aux_carry_flag, .overflow_flag, .parity_flag,
    .user_flag_zero, .user_flag_one, .bank_select, .general_flag_one,
    .general_flag_zero);
  asf_core_model i_asf_core_model (
    .pclk, .op_valid, .op_code, .op_a, .op_b, .op_bit, .acc);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic end_of_test();
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    fails++;
    end_of_test();
  end
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(PSW_ADDR, 1'b0, 8'h00);
    chk(rd, 32'h0);
    apb(12'hFFC, 1'b1, 8'hFF);
    chk(32'(er), 32'h1);
    apb(12'hFFC, 1'b0, 8'h00);
    chk({rd[31:1], er}, 32'h1);
    for (int i = 0; i <= 23; i++) begin
      if (i < 23) begin
        i_asf_core_model.exec(vec[i].op, vec[i].a, vec[i].b, vec[i].bt);
      end else begin
        i_asf_core_model.idle();
      end
      #1;
      if (i > 0) begin
        chk(32'({carry_flag, aux_carry_flag, overflow_flag}),
            32'(vec[i-1].f));
      end
    end
    apb(POWER_CONTROL_ADDR, 1'b1, 8'hFF);
    apb(POWER_CONTROL_ADDR, 1'b0, 8'h00);
    chk(rd, 32'h9F);
    chk(32'({general_flag_one, general_flag_zero}), 32'h3);
    i_asf_core_model.set_acc(8'h07);
    apb(PSW_ADDR, 1'b1, 8'hFE);
    apb(PSW_ADDR, 1'b0, 8'h00);
    chk(rd, 32'hFF);
    chk(32'({user_flag_zero, user_flag_one, bank_select}), 32'hF);
    apb(PSW_ADDR, 1'b1, 8'h00);
    apb(PSW_ADDR, 1'b0, 8'h00);
    chk(rd, 32'h01);
    i_asf_core_model.set_acc(8'h03);
    apb(PSW_ADDR, 1'b0, 8'h00);
    chk(rd, 32'h00);
    apb(POWER_CONTROL_ADDR, 1'b1, 8'h00);
    apb(POWER_CONTROL_ADDR, 1'b0, 8'h00);
    chk(32'({general_flag_one, general_flag_zero}), 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(PSW_ADDR, 1'b0, 8'h00);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
